// file: ssc_pkg.sv
// Package for the subclass-1 sysref sync control block
package ssc_pkg;

  // Register byte offsets (one aligned word each)
  localparam logic [7:0] OFF_LINK_CFG  = 8'h00;
  localparam logic [7:0] OFF_SKIP_CFG  = 8'h04;
  localparam logic [7:0] OFF_DSP_CFG   = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0c;
  localparam logic [7:0] OFF_EVT_COUNT = 8'h10;

  // Link config field positions
  localparam int LINK_MODE_LO_BIT   = 0;
  localparam int LINK_MODE_HI_BIT   = 1;
  localparam int LINK_GATE_SEL_BIT  = 2;
  localparam int LINK_CLK_DSP_BIT   = 3;
  localparam int LINK_MCS_SRC_BIT   = 4;
  // Skip config field positions
  localparam int SKIP_COUNT_LSB     = 0;
  localparam int SKIP_EN_BIT        = 8;
  // DSP config field positions
  localparam int DSP_ASYNC_BIT      = 0;
  localparam int DSP_REPEAT_BIT     = 1;

  // Reset values
  localparam logic [4:0] LINK_CFG_RST = 5'h00;
  localparam logic [8:0] SKIP_CFG_RST = 9'h000;
  localparam logic [1:0] DSP_CFG_RST  = 2'h0;

  // Response modes of the link
  localparam logic [1:0] MODE_FIRST_LO = 2'h1;

  // Packed link configuration
  typedef struct packed {
    logic mcs_src;
    logic clk_from_dsp;
    logic gate_sel;
    logic [1:0] mode;
  } ssc_link_cfg_type;

  // Packed DSP configuration
  typedef struct packed {
    logic repeat_en;
    logic async_en;
  } ssc_dsp_cfg_type;

  // First-pulse arming state
  typedef enum logic [2:0] {
    ARM_IDLE  = 3'b001,
    ARM_SKIP  = 3'b010,
    ARM_READY = 3'b100
  } ssc_arm_type;

endpackage : ssc_pkg

// file: ssc_sync_ctrl.sv
// SYSREF response and divider reset control for the subclass-1 link
// Operation
// RL1: Upper mode bit: act on every pulse
// RL2: Else act on first pulse after arming
// RL3: Skip enabled: drop programmed count first
// RL4: Host should enable a single pulse only
// RL5: Gate select: external pin replaces mode
// RL6: Synchronous: sample clock from device clock
// RL7: Clock-from-DSP bit selects DSP clock
// RL8: Async: regenerate sync from passed sysref
// RL9: Sync source bit uses regenerated sync
// RL10: Host sets sync source with clock bit
// RL11: Async enable lets sysref reset DSP
// RL12: Async: DSP makes clock and sync
// RL13: Async mode ignores external gate pin
// RL14: Repeat bit: every or first divider reset
// RL15: One-shot sysref: host sets repeat bit
// RL16: Continuous sysref: host clears repeat bit
// RL17: Host holds chip reset through power-up
// RL18: Host waits for initialisation after reset
// RL19: Host waits settle time before divider reset
// RL20: Mode 10 lets pulses set boundary
// RL21: Host never resets FIFO in async mode
// RL22: Rising edge gives one alignment event
module ssc_sync_ctrl (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Sysref and gate pins
  input  wire logic        sysref_in,
  input  wire logic        sysref_gate_pin,
  // DSP side
  input  wire logic        dsp_divider_valid,
  output logic             passed_sync_out,
  output logic             divider_reset,
  // Link side
  output logic             link_align,
  output logic             link_clock_from_dsp,
  output logic             link_sync_sel_regen
);

  ssc_pkg::ssc_link_cfg_type link_cfg_reg;
  ssc_pkg::ssc_dsp_cfg_type  dsp_cfg_reg;
  logic [7:0]               skip_count_reg;
  logic                     skip_en_reg;
  ssc_pkg::ssc_arm_type      arm_reg;
  logic [7:0]               skip_left_reg;
  logic                     sysref_d_reg;
  logic                     regen_d_reg;
  logic                     div_done_reg;
  logic [15:0]              evt_count_reg;
  logic                     mode_lo_d_reg;
  logic                     wr_en;
  logic                     rd_en;
  logic                     addr_ok;
  logic                     sysref_rise;
  logic                     regen_sync;
  logic                     regen_rise;
  logic                     eff_rise;
  logic                     async_mode;
  logic                     arm_trigger;
  logic                     pass_first;
  logic                     gate_open;

  // Bus strobes; the slave answers with no wait state
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign addr_ok = (paddr == ssc_pkg::OFF_LINK_CFG) || (paddr == ssc_pkg::OFF_SKIP_CFG) ||
                   (paddr == ssc_pkg::OFF_DSP_CFG) || (paddr == ssc_pkg::OFF_STATUS) ||
                   (paddr == ssc_pkg::OFF_EVT_COUNT);
  assign pslverr = psel && penable && !addr_ok;

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_cfg_reg   <= ssc_pkg::LINK_CFG_RST;
      skip_count_reg <= ssc_pkg::SKIP_CFG_RST[7:0];
      skip_en_reg    <= ssc_pkg::SKIP_CFG_RST[8];
      dsp_cfg_reg    <= ssc_pkg::DSP_CFG_RST;
    end else if (wr_en) begin
      case (paddr)
        ssc_pkg::OFF_LINK_CFG: begin
          link_cfg_reg <= pwdata[ssc_pkg::LINK_MCS_SRC_BIT:ssc_pkg::LINK_MODE_LO_BIT];
        end
        ssc_pkg::OFF_SKIP_CFG: begin
          skip_count_reg <= pwdata[ssc_pkg::SKIP_COUNT_LSB +: 8];
          skip_en_reg    <= pwdata[ssc_pkg::SKIP_EN_BIT];
        end
        ssc_pkg::OFF_DSP_CFG: begin
          dsp_cfg_reg <= pwdata[ssc_pkg::DSP_REPEAT_BIT:ssc_pkg::DSP_ASYNC_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux from flip-flops; data is registered to the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      case (paddr)
        ssc_pkg::OFF_LINK_CFG:  prdata <= {27'h0, link_cfg_reg};
        ssc_pkg::OFF_SKIP_CFG:  prdata <= {23'h0, skip_en_reg, skip_count_reg};
        ssc_pkg::OFF_DSP_CFG:   prdata <= {30'h0, dsp_cfg_reg};
        ssc_pkg::OFF_STATUS:    prdata <= {27'h0, div_done_reg, skip_left_reg == 8'h00,
                                           arm_reg};
        ssc_pkg::OFF_EVT_COUNT: prdata <= {16'h0, evt_count_reg};
        default:                prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Clock and sync source selects go straight to the link
  assign link_clock_from_dsp = link_cfg_reg.clk_from_dsp; // RL6 RL7
  assign link_sync_sel_regen = link_cfg_reg.mcs_src;      // RL9
  assign async_mode          = link_cfg_reg.clk_from_dsp;

  // Edge history of sysref, the regenerated sync and the low mode bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysref_d_reg  <= 1'b0;
      regen_d_reg   <= 1'b0;
      mode_lo_d_reg <= 1'b0;
    end else begin
      sysref_d_reg  <= sysref_in;
      regen_d_reg   <= regen_sync;
      mode_lo_d_reg <= link_cfg_reg.mode[0];
    end
  end

  assign sysref_rise = sysref_in && !sysref_d_reg; // RL22
  // Regenerated sync: async passes sysref through, else divider valid
  assign regen_sync  = dsp_cfg_reg.async_en ? sysref_in : dsp_divider_valid; // RL8 RL12
  assign regen_rise  = regen_sync && !regen_d_reg;
  assign eff_rise    = link_cfg_reg.mcs_src ? regen_rise : sysref_rise; // RL9

  // Arming happens on the low mode bit going 0 to 1
  assign arm_trigger = link_cfg_reg.mode[0] && !mode_lo_d_reg; // RL2

  // First-pulse arming with optional skip count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_reg       <= ssc_pkg::ARM_IDLE;
      skip_left_reg <= 8'h00;
    end else if (arm_trigger) begin
      // Skip has priority over the plain first-pulse case
      if (skip_en_reg && skip_count_reg != 8'h00) begin // RL3
        arm_reg       <= ssc_pkg::ARM_SKIP;
        skip_left_reg <= skip_count_reg;
      end else begin
        arm_reg       <= ssc_pkg::ARM_READY;
        skip_left_reg <= 8'h00;
      end
    end else begin
      case (arm_reg)
        ssc_pkg::ARM_IDLE: begin
        end
        ssc_pkg::ARM_SKIP: begin
          if (eff_rise) begin // RL3
            skip_left_reg <= skip_left_reg - 8'h01;
            if (skip_left_reg == 8'h01) begin
              arm_reg <= ssc_pkg::ARM_READY;
            end
          end
        end
        ssc_pkg::ARM_READY: begin
          if (eff_rise && !link_cfg_reg.mode[1] && !link_cfg_reg.gate_sel) begin
            arm_reg <= ssc_pkg::ARM_IDLE; // RL2
          end
        end
        default: arm_reg <= ssc_pkg::ARM_IDLE;
      endcase
    end
  end

  assign pass_first = (arm_reg == ssc_pkg::ARM_READY) && !arm_trigger;
  // Gate pin counts only outside async mode, which ignores it
  assign gate_open  = sysref_gate_pin && !async_mode; // RL5 RL13

  // One alignment pulse per accepted edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_align <= 1'b0;
    end else if (link_cfg_reg.gate_sel && !async_mode) begin
      link_align <= eff_rise && gate_open; // RL5
    end else if (link_cfg_reg.mode[1]) begin
      link_align <= eff_rise; // RL1 RL20
    end else begin
      link_align <= eff_rise && pass_first; // RL2 RL22
    end
  end

  // Divider reset from async sysref: every pulse or only the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_reset <= 1'b0;
      div_done_reg  <= 1'b0;
    end else if (!dsp_cfg_reg.async_en) begin
      divider_reset <= 1'b0;
      div_done_reg  <= 1'b0;
    end else begin
      divider_reset <= sysref_rise && (dsp_cfg_reg.repeat_en || !div_done_reg); // RL11 RL14
      if (sysref_rise) begin
        div_done_reg <= 1'b1; // RL14
      end
    end
  end

  // Passed sysref copy for the DSP
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      passed_sync_out <= 1'b0;
    end else begin
      passed_sync_out <= sysref_in; // RL8
    end
  end

  // Alignment event counter for software visibility; wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_count_reg <= 16'h0000;
    end else if (link_align) begin
      evt_count_reg <= evt_count_reg + 16'h0001;
    end
  end

  // Assertions
  AST_ALL_PULSES: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    (eff_rise && link_cfg_reg.mode[1] && !link_cfg_reg.gate_sel) |=> link_align)
    else $error("all-pulse mode missed an edge");
  AST_NO_EDGE_NO_ALIGN: assert property (@(posedge pclk) disable iff (!presetn) // RL22
    !$past(eff_rise) |-> !link_align)
    else $error("alignment without an edge");
  AST_FIRST_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    (eff_rise && arm_reg == ssc_pkg::ARM_READY && !arm_trigger && link_cfg_reg.mode == 2'h1
     && !link_cfg_reg.gate_sel) |=> (arm_reg == ssc_pkg::ARM_IDLE && link_align))
    else $error("first pulse not taken once");
  AST_SKIP_BLOCKS: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    (arm_reg == ssc_pkg::ARM_SKIP && !link_cfg_reg.mode[1] && !link_cfg_reg.gate_sel)
    |=> !link_align)
    else $error("pulse passed during skip");
  AST_GATE_LOW: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    (link_cfg_reg.gate_sel && !async_mode && !sysref_gate_pin) |=> !link_align)
    else $error("gate low but aligned");
  AST_SRC_SEL: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    link_clock_from_dsp == link_cfg_reg.clk_from_dsp)
    else $error("clock source mismatch");
  AST_DIV_FIRST: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    (div_done_reg && !dsp_cfg_reg.repeat_en && $stable(dsp_cfg_reg)) |=> !divider_reset)
    else $error("divider reset repeated");
  AST_DIV_EVERY: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    (sysref_rise && dsp_cfg_reg.async_en && dsp_cfg_reg.repeat_en) |=> divider_reset)
    else $error("divider reset missed");
  AST_PASS: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    passed_sync_out == $past(sysref_in))
    else $error("passed sync wrong");

  // Checks below guard the source selects, the arming machine, the divider reset and the alignment pulse.
  // Most of them look one cycle ahead because link_align, divider_reset and arm_reg are registered.
  // Config writes can land in the same cycle as an edge, so the regen source
  // antecedent demands a stable config to avoid false alarms.

  // Sync source select follows its config bit
  AST_SYNC_SEL: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    link_sync_sel_regen == link_cfg_reg.mcs_src)
    else $error("sync source mismatch");

  // Async mode: gate pin has no say, all-pulse mode still aligns
  AST_ASYNC_NO_GATE: assert property (@(posedge pclk) disable iff (!presetn) // RL13
    (async_mode && link_cfg_reg.mode[1] && eff_rise) |=> link_align)
    else $error("async mode blocked by gate");

  // Async regen path: sysref edges reach the link through the DSP
  AST_REGEN_SRC: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    (link_cfg_reg.mcs_src && dsp_cfg_reg.async_en && link_cfg_reg.mode[1]
     && !link_cfg_reg.gate_sel && sysref_rise && $stable(dsp_cfg_reg))
    |=> link_align)
    else $error("regen sync edge lost");

  // Without async reset the regen path follows divider valid only
  AST_VALID_SRC: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    (link_cfg_reg.mcs_src && !dsp_cfg_reg.async_en && !dsp_divider_valid) |-> !eff_rise)
    else $error("regen edge without divider valid");

  // No divider reset unless async sysref reset is enabled
  AST_DIV_OFF: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    !dsp_cfg_reg.async_en |=> !divider_reset)
    else $error("divider reset while disabled");

  // Low mode bit rising always leaves idle
  AST_ARM: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    arm_trigger |=> arm_reg != ssc_pkg::ARM_IDLE)
    else $error("arming lost");

  // Skip count not yet spent keeps the machine skipping
  AST_SKIP_COUNT: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    (arm_reg == ssc_pkg::ARM_SKIP && eff_rise && skip_left_reg != 8'h01 && !arm_trigger)
    |=> arm_reg == ssc_pkg::ARM_SKIP)
    else $error("skip ended early");

  // All-pulse mode never consumes the armed state
  AST_ALL_STAY: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    (arm_reg == ssc_pkg::ARM_READY && link_cfg_reg.mode[1] && !arm_trigger && eff_rise)
    |=> arm_reg == ssc_pkg::ARM_READY)
    else $error("all-pulse mode disarmed");

  // An edge needs a low cycle first, so alignments never touch
  AST_ALIGN_ONE: assert property (@(posedge pclk) disable iff (!presetn) // RL22
    link_align |=> !link_align)
    else $error("alignment pulse too long");

  COV_GATE: cover property (@(posedge pclk) disable iff (!presetn)
    link_cfg_reg.gate_sel && sysref_gate_pin ##1 link_align);
  COV_ALL: cover property (@(posedge pclk) disable iff (!presetn)
    link_cfg_reg.mode[1] && link_align);
  COV_FIRST: cover property (@(posedge pclk) disable iff (!presetn)
    arm_reg == ssc_pkg::ARM_READY ##1 link_align);
  COV_SKIP: cover property (@(posedge pclk) disable iff (!presetn)
    arm_reg == ssc_pkg::ARM_SKIP ##[1:100] arm_reg == ssc_pkg::ARM_READY);
  COV_DIV: cover property (@(posedge pclk) disable iff (!presetn) divider_reset);

endmodule : ssc_sync_ctrl

// file: ssc_sysref_src.sv
// SYSREF source model driving bursts of pulses into the sync control block
module ssc_sysref_src (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Burst request
  input  wire logic       req,
  input  wire logic [7:0] num,
  // Pulse line and status
  output logic            sysref,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_reg;
  logic [2:0] ph_reg;
  // Pulses of two high, four low cycles; one pulse for link setup,
  // a long burst stands in for a continuous clock-like sysref
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_reg <= 8'h00;
      ph_reg   <= 3'h0;
    end else if (req && left_reg == 8'h00) begin
      left_reg <= num;
      ph_reg   <= 3'h0;
    end else if (left_reg != 8'h00) begin
      ph_reg <= (ph_reg == 3'h5) ? 3'h0 : ph_reg + 3'h1;
      if (ph_reg == 3'h5) begin
        left_reg <= left_reg - 8'h01;
      end
    end
  end
  // Line rests low between bursts
  assign sysref = (left_reg != 8'h00) && (ph_reg < 3'h2);
  assign busy   = (left_reg != 8'h00);
endmodule : ssc_sysref_src

// file: tb_top.sv
// Self-checking bench for the sysref sync control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, num;
  logic [31:0] pwdata, prdata, rd;
  logic        gate_pin, div_valid, sref, req, busy, s_d;
  logic        passed, div_rst, align, clk_dsp, sync_sel;
  int          failures, num_checks, n_al, n_dr, exp_tot, k;

  ssc_sync_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sysref_in(sref), .sysref_gate_pin(gate_pin),
    .dsp_divider_valid(div_valid), .passed_sync_out(passed), .divider_reset(div_rst),
    .link_align(align), .link_clock_from_dsp(clk_dsp), .link_sync_sel_regen(sync_sel));
  ssc_sysref_src src (.pclk(pclk), .presetn(presetn), .req(req), .num(num),
    .sysref(sref), .busy(busy));

  // Clock
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // Pulse counts and passed copy, sampled mid-cycle where outputs are settled
  always @(posedge pclk) s_d <= sref;
  always @(negedge pclk) begin
    if (align === 1'b1) n_al++;
    if (div_rst === 1'b1) n_dr++;
    if (busy === 1'b1) chk({31'h0, passed}, {31'h0, s_d}, "passed");
  end

  // APB transfer; request held until pready seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic int exp_al(input logic [31:0] l, s, d, input int n);
    if (l[4] && !d[0]) return 0; // divider valid held low
    if (l[2] && !l[3]) return gate_pin ? n : 0;
    if (l[1]) return n;
    if (!l[0]) return 0;
    if (s[8]) return (n > s[7:0]) ? 1 : 0;
    return (n > 0) ? 1 : 0;
  endfunction : exp_al

  function automatic int exp_dr(input logic [31:0] d, input int n);
    if (!d[0]) return 0;
    return d[1] ? n : ((n > 0) ? 1 : 0);
  endfunction : exp_dr

  // Clear config, program it, send n pulses, compare event counts
  task automatic trial(input logic [31:0] l, s, d, input int n, input string nm);
    apb(1'b1, ssc_pkg::OFF_LINK_CFG, 32'h0);
    apb(1'b1, ssc_pkg::OFF_DSP_CFG, 32'h0);
    apb(1'b1, ssc_pkg::OFF_SKIP_CFG, s);
    apb(1'b1, ssc_pkg::OFF_DSP_CFG, d);
    apb(1'b1, ssc_pkg::OFF_LINK_CFG, l);
    @(negedge pclk);
    chk({30'h0, clk_dsp, sync_sel}, {30'h0, l[3], l[4]}, "link sel");
    n_al = 0;
    n_dr = 0;
    @(posedge pclk);
    req <= 1'b1;
    num <= n[7:0];
    @(posedge pclk);
    req <= 1'b0;
    @(posedge pclk);
    while (busy === 1'b1) @(posedge pclk);
    repeat (3) @(posedge pclk);
    chk(n_al, exp_al(l, s, d, n), "aligns");
    chk(n_dr, exp_dr(d, n), "div resets");
    exp_tot += exp_al(l, s, d, n);
    $display("test %s done", nm);
  endtask : trial

  initial begin
    {psel, penable, pwrite, req, gate_pin, div_valid, s_d} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    num = 8'h00;
    presetn = 1'b0;
    void'($urandom(12));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, ssc_pkg::OFF_LINK_CFG, 32'h0);
    chk(rd, {27'h0, ssc_pkg::LINK_CFG_RST}, "link rst");
    apb(1'b0, ssc_pkg::OFF_SKIP_CFG, 32'h0);
    chk(rd, {23'h0, ssc_pkg::SKIP_CFG_RST}, "skip rst");
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    k = $urandom_range(1, 4);
    trial(32'h2, 32'h0, 32'h0, 4, "all");
    trial(32'h1, 32'h0, 32'h0, 3, "first");
    trial(32'h1, 32'h100 | k, 32'h0, k + 2, "skip");
    trial(32'h1, 32'h100 | k, 32'h0, k, "skip all");
    gate_pin <= 1'b1;
    trial(32'h4, 32'h0, 32'h0, 3, "gate on");
    gate_pin <= 1'b0;
    trial(32'h4, 32'h0, 32'h0, 3, "gate off");
    trial(32'he, 32'h0, 32'h1, 3, "async first");
    trial(32'h1a, 32'h0, 32'h3, 3, "async all");
    trial(32'h12, 32'h0, 32'h0, 2, "valid src");
    apb(1'b0, ssc_pkg::OFF_EVT_COUNT, 32'h0);
    chk({16'h0, rd[15:0]}, exp_tot, "evt count");
    close_out();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #100000;
    failures++;
    close_out();
  end
endmodule : tb_top
